// >>> hdl/dmie_exec.sv
`timescale 1ns/1ps
`include "dmie_defines.svh"
// ==========================================
// data move execution unit
// Operation
// - copy moves source value to destination, source and flags unchanged
// - accumulator may be copy source or destination
// - copy cycle one: decode q1, read source q2, no write q4
// - copy cycle two: no read, write destination q4; two cycles, q4 of cycle two held while mem_wait is set
// - opcode 0000 0001 kkkk kkkk loads literal low nibble into bank register
// - move destination bit zero goes to accumulator, one back to register
// - access bit zero selects access bank instead of bank register
module dmie_exec (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 run,
    input  wire logic [15:0]          instr,
    input  wire logic                 instr_valid,
    input  wire logic                 mem_wait,
    input  wire logic [7:0]           mem_rdata,
    output dmie_pkg::dmie_mem_req_t   mem_req_q,
    output logic [7:0]                acc_q,
    output logic [7:0]                bank_select_reg_q,
    output logic [7:0]                status_q,
    output logic                      fetch_q,
    output logic                      busy_q
);
    logic [1:0]              phase;
    logic                    cyc_end;
    dmie_pkg::dmie_state_t   state_q;
    logic [15:0]             ir_q;
    logic [11:0]             dst_q;
    logic [7:0]              data_q;
    logic [11:0]             short_addr;
    logic                    is_move;
    logic                    is_copy;
    logic                    is_bank;
    logic                    advance;

    // stall the phase counter while memory asks for an extra cycle
    assign advance = run && !(mem_wait && state_q == dmie_pkg::DMIE_ST_WAIT);

    dmie_phase_gen u_phase (
        .clk       (clk),
        .rst_n     (rst_n),
        .run       (advance),
        .phase_q   (phase),
        .cycle_end (cyc_end)
    );

    // ==========================================
    // decode
    assign is_move = (ir_q[15:12] == `DMIE_OP_MOVE_HI) && (ir_q[11:10] == `DMIE_OP_MOVE_MID);
    assign is_copy = (ir_q[15:12] == `DMIE_OP_COPY_HI);
    assign is_bank = (ir_q[15:8] == `DMIE_OP_BANK_HI);

    always_comb begin
        if (ir_q[8]) begin
            short_addr = {bank_select_reg_q[3:0], ir_q[7:0]};
        end else if (ir_q[7:0] < `DMIE_ACCESS_SPLIT) begin
            short_addr = {4'h0, ir_q[7:0]};
        end else begin
            short_addr = {`DMIE_ACCESS_HIBNK, ir_q[7:0]};
        end
    end

    // latch the fetched word at q1 of each cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_q <= 16'h0000;
        end else if (advance && phase == 2'h0) begin
            // an empty slot latches a no-op so an old command never runs twice
            ir_q <= instr_valid ? instr : 16'h0000;
        end
    end

    // prefetch request in q4 overlaps current execution
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_q <= 1'b0;
        end else begin
            fetch_q <= advance && phase == 2'h3;
        end
    end

    // ==========================================
    // two-word copy sequencing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= dmie_pkg::DMIE_ST_IDLE;
            dst_q   <= 12'h000;
            busy_q  <= 1'b0;
        end else if (advance) begin
            case (state_q)
                dmie_pkg::DMIE_ST_IDLE: begin
                    if (cyc_end && is_copy) begin
                        state_q <= dmie_pkg::DMIE_ST_COPY2;
                        busy_q  <= 1'b1;
                    end
                end
                dmie_pkg::DMIE_ST_COPY2: begin
                    if (phase == 2'h0) begin
                        dst_q <= instr[11:0];
                    end
                    if (phase == 2'h2) begin
                        state_q <= dmie_pkg::DMIE_ST_WAIT;
                    end
                end
                dmie_pkg::DMIE_ST_WAIT: begin
                    // entered on every copy at q3 of cycle two; phases stall here while memory waits
                    if (cyc_end) begin
                        state_q <= dmie_pkg::DMIE_ST_IDLE;
                        busy_q  <= 1'b0;
                    end
                end
                default: begin
                    state_q <= dmie_pkg::DMIE_ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // memory request per phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req_q <= '0;
        end else begin
            mem_req_q <= '0;
            if (advance && state_q == dmie_pkg::DMIE_ST_IDLE && phase == 2'h1) begin
                // read source in q2, full address for copy, short address for move
                if (is_copy && ir_q[11:0] != `DMIE_ACC_ADDR) begin
                    mem_req_q.rd   <= 1'b1;
                    mem_req_q.addr <= ir_q[11:0];
                end else if (is_move) begin
                    mem_req_q.rd   <= 1'b1;
                    mem_req_q.addr <= short_addr;
                end
            end
            // destination write in q4 of cycle two
            if (advance && state_q == dmie_pkg::DMIE_ST_WAIT && phase == 2'h3
                && dst_q != `DMIE_ACC_ADDR) begin
                mem_req_q.wr    <= 1'b1;
                mem_req_q.addr  <= dst_q;
                mem_req_q.wdata <= data_q;
            end
            // write back to register when d is one
            if (advance && state_q == dmie_pkg::DMIE_ST_IDLE && phase == 2'h3
                && is_move && ir_q[9]) begin
                mem_req_q.wr    <= 1'b1;
                mem_req_q.addr  <= short_addr;
                mem_req_q.wdata <= mem_rdata;
            end
        end
    end

    // capture source at the end of q4, when read data has arrived
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= 8'h00;
        end else if (advance && state_q == dmie_pkg::DMIE_ST_IDLE && phase == 2'h3) begin
            data_q <= (ir_q[11:0] == `DMIE_ACC_ADDR) ? acc_q : mem_rdata;
        end
    end

    // ==========================================
    // accumulator and flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q    <= `DMIE_ACC_RST;
            status_q <= 8'h00;
        end else if (advance && phase == 2'h3) begin
            // accumulator as copy destination, flags kept
            if (state_q == dmie_pkg::DMIE_ST_WAIT && dst_q == `DMIE_ACC_ADDR) begin
                acc_q <= data_q;
            end else if (state_q == dmie_pkg::DMIE_ST_IDLE && is_move) begin
                // d zero routes to accumulator
                // read data stands only in this cycle, so it is used directly
                if (!ir_q[9]) begin
                    acc_q <= mem_rdata;
                end
                status_q[`DMIE_FLAG_N] <= mem_rdata[7];
                status_q[`DMIE_FLAG_Z] <= (mem_rdata == 8'h00);
            end
        end
    end

    // literal low nibble to bank register, upper bits zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_select_reg_q <= {4'h0, `DMIE_BANK_RST};
        end else if (advance && phase == 2'h3 && state_q == dmie_pkg::DMIE_ST_IDLE
                     && is_bank) begin
            bank_select_reg_q <= {4'h0, ir_q[3:0]};
        end
    end
endmodule

// >>> hdl/dmie_phase_gen.sv
`timescale 1ns/1ps
`include "dmie_defines.svh"
// ==========================================
// four phase sequencer
module dmie_phase_gen (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    output logic [1:0]      phase_q,
    output logic            cycle_end
);
    // phases q1..q4 as codes 0..3; held at the current phase while stalled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 2'h0;
        end else if (run) begin
            phase_q <= phase_q + 2'h1;
        end
    end

    assign cycle_end = run && (phase_q == 2'(`DMIE_PHASES - 1));
endmodule

// >>> pkg/dmie_defines.svh
`ifndef DMIE_DEFINES_SVH
`define DMIE_DEFINES_SVH
// ==========================================
// opcode patterns
`define DMIE_OP_MOVE_HI   4'h5
`define DMIE_OP_MOVE_MID  2'h0
`define DMIE_OP_COPY_HI   4'hC
`define DMIE_OP_COPY_W2   4'hF
`define DMIE_OP_BANK_HI   8'h01
// ==========================================
// address map, reset values and flag bit positions
`define DMIE_ACC_ADDR     12'hFE8
`define DMIE_ACCESS_SPLIT 8'h60
`define DMIE_ACCESS_HIBNK 4'hF
`define DMIE_BANK_RST     4'h0
`define DMIE_ACC_RST      8'h00
`define DMIE_FLAG_N       4
`define DMIE_FLAG_Z       2
// ==========================================
// phase counts
`define DMIE_PHASES       4
`endif

// >>> pkg/dmie_pkg.sv
package dmie_pkg;
    // ==========================================
    // execution states
    typedef enum logic [1:0] {
        DMIE_ST_IDLE  = 2'b00,
        DMIE_ST_COPY2 = 2'b01,
        DMIE_ST_WAIT  = 2'b10
    } dmie_state_t;

    // one data memory request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } dmie_mem_req_t;
endpackage

// >>> test/dmie_exec_props.sv
`timescale 1ns/1ps
// ==========================================
// port checker
module dmie_exec_props (
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire dmie_pkg::dmie_mem_req_t mem_req_q,
    input wire logic [7:0]              acc_q,
    input wire logic [7:0]              bank_select_reg_q,
    input wire logic [7:0]              status_q,
    input wire logic                    fetch_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // the three phases after a read carry no other read, and the first carries no write
    sequence s_after_read;
        !mem_req_q.rd && !mem_req_q.wr ##1 !mem_req_q.rd ##1 !mem_req_q.rd;
    endsequence
    a_rd_wr_excl: assert property (mem_req_q.rd |-> !mem_req_q.wr)
        else $error("read and write together");
    a_read_spacing: assert property (mem_req_q.rd |=> s_after_read)
        else $error("read phase order broken");
    a_write_spacing: assert property (mem_req_q.wr |=> !mem_req_q.wr [*3])
        else $error("two writes in one cycle");
    a_write_no_read: assert property (mem_req_q.wr |=> !mem_req_q.rd)
        else $error("read right after write");
    a_fetch_spacing: assert property (fetch_q |=> !fetch_q [*3])
        else $error("fetch faster than four phases");
    a_bank_upper_zero: assert property (bank_select_reg_q[7:4] == 4'h0)
        else $error("bank upper nibble set");
    a_bank_keeps_flags: assert property ($changed(bank_select_reg_q) |-> $stable(status_q))
        else $error("bank load touched flags");
    a_bank_keeps_acc: assert property ($changed(bank_select_reg_q) |-> $stable(acc_q))
        else $error("bank load touched accumulator");
endmodule
bind dmie_exec dmie_exec_props u_props (.clk, .rst_n, .mem_req_q, .acc_q,
    .bank_select_reg_q, .status_q, .fetch_q);

// >>> test/dmie_mem_model.sv
`timescale 1ns/1ps
// ==========================================
// data memory model
module dmie_mem_model (
    input  wire logic                    clk,
    input  wire dmie_pkg::dmie_mem_req_t req,
    output logic [7:0]                   rdata
);
    logic [7:0] mem [4096];
    // data valid the cycle after a read; otherwise inverted so stale data never passes
    always @(posedge clk) begin
        rdata <= req.rd ? mem[req.addr] : ~rdata;
        if (req.wr) begin
            mem[req.addr] <= req.wdata;
        end
    end
endmodule

// >>> test/test_data_move_instruction_exec.sv
`timescale 1ns/1ps
module test_data_move_instruction_exec;
    logic                    clk, rst_n, run, instr_valid, mem_wait, fetch_q, busy_q;
    logic [15:0]             instr;
    logic [7:0]              mem_rdata, acc_q, bank_select_reg_q, status_q;
    dmie_pkg::dmie_mem_req_t mem_req_q;
    int                      n_errors, samples_checked, cycles;
    logic [7:0]              lits [3] = '{8'hF0, 8'hA7, 8'h25};

    dmie_exec DUT (.clk, .rst_n, .run, .instr, .instr_valid, .mem_wait, .mem_rdata,
        .mem_req_q, .acc_q, .bank_select_reg_q, .status_q, .fetch_q, .busy_q);
    dmie_mem_model u_mem (.clk, .req(mem_req_q), .rdata(mem_rdata));

    // ==========================================
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // a word held one full four-phase slot is seen by exactly one q1
    task automatic slot(input logic [15:0] w, input logic v);
        instr = w;
        instr_valid = v;
        repeat (4) @(negedge clk);
    endtask
    task automatic copy(input logic [11:0] s, input logic [11:0] d, input logic w);
        slot({4'hC, s}, 1'b1);
        mem_wait = w;
        slot({4'hF, d}, 1'b1);
        mem_wait = 1'b0;
        repeat (3) slot(16'h0000, 1'b0);
    endtask
    function automatic logic [7:0] flags();
        return {6'h00, status_q[4], status_q[2]};
    endfunction

    task automatic t_bank();
        foreach (lits[i]) begin
            slot({8'h01, lits[i]}, 1'b1);
            slot(16'h0000, 1'b0);
            check(bank_select_reg_q, {4'h0, lits[i][3:0]});
        end
    endtask
    task automatic t_move();
        u_mem.mem[12'h010] = 8'h80;
        u_mem.mem[12'h510] = 8'h00;
        slot(16'h5010, 1'b1);
        slot(16'h0000, 1'b0);
        check(acc_q, 8'h80);
        slot(16'h5110, 1'b1);
        slot(16'h0000, 1'b0);
        check(acc_q, 8'h00);
        check(flags(), 8'h01);
        slot(16'h5210, 1'b1);
        slot(16'h0000, 1'b0);
        check(acc_q, 8'h00);
        check(u_mem.mem[12'h010], 8'h80);
        check(flags(), 8'h02);
    endtask
    task automatic t_copy_mem();
        u_mem.mem[12'h123] = 8'h33;
        u_mem.mem[12'hABC] = 8'h11;
        copy(12'h123, 12'hABC, 1'b0);
        check(u_mem.mem[12'hABC], 8'h33);
        check(u_mem.mem[12'h123], 8'h33);
        check(flags(), 8'h02);
    endtask
    task automatic t_copy_acc();
        copy(12'h123, 12'hFE8, 1'b1);
        check(acc_q, 8'h33);
        u_mem.mem[12'hFFF] = 8'h00;
        copy(12'hFE8, 12'hFFF, 1'b0);
        check(u_mem.mem[12'hFFF], 8'h33);
    endtask

    // reset, then the scenarios back to back
    initial begin
        rst_n = 1'b0;
        run = 1'b1;
        instr = 16'h0000;
        instr_valid = 1'b0;
        mem_wait = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        t_bank();
        t_move();
        t_copy_mem();
        t_copy_acc();
        end_sim();
    end
endmodule
